/* verilog/etw_pkg.sv */
// etw_pkg: constants, states and commands shared by both ends of the two-wire EEPROM link.
// assumes a 25 MHz user clock; the device end also runs on a free-running link clock.
package etw_pkg;
    localparam logic [3:0] DEV_TYPE = 4'hA;
    localparam int ADDR_W = 7;
    localparam int PAGE_W = 4;
    localparam int MEM_DEPTH = 128;
    localparam int PAGE_BYTES = 16;
    localparam logic [3:0] BYTE_BITS = 4'h8;
    // self-timed programming time and its count on the user clock
    localparam int T_WR_MS = 5;
    localparam int MCLK_HZ = 25_000_000;
    localparam int MCLK_NS = 40;
    localparam int T_WR_CYC = T_WR_MS * (MCLK_HZ / 1000);
    // serial clock period; each quarter rounds up so high, and every low but the one-quarter low of a start or stop from idle, stay at least 1.2 us
    localparam int SCL_PERIOD_NS = 2500;
    localparam int QTR_CYC = (SCL_PERIOD_NS / 4 + MCLK_NS - 1) / MCLK_NS;
    localparam logic [5:0] QTR_LAST = 6'(QTR_CYC - 1);
    // device link states, gray along address, ack, byte address, data
    typedef enum logic [2:0] {
        D_IDLE = 3'h0,
        D_ADDR = 3'h1,
        D_ACK = 3'h3,
        D_WADR = 3'h2,
        D_WDAT = 3'h6,
        D_RDAT = 3'h7,
        D_RACK = 3'h5,
        D_WAIT = 3'h4
    } etw_dst_t;
    typedef enum logic [1:0] {
        M_IDLE = 2'h0,
        M_START = 2'h1,
        M_BYTE = 2'h3,
        M_STOP = 2'h2
    } etw_mst_t;
    typedef enum logic [1:0] {
        CMD_START = 2'h0,
        CMD_STOP = 2'h1,
        CMD_WRITE = 2'h2,
        CMD_READ = 2'h3
    } etw_cmd_t;
endpackage : etw_pkg

/* verilog/etw_if.sv */
// etw_if: the two-wire link between bus master and EEPROM device.
// assumes open-drain data: a party pulls low while its enable is high.
`timescale 1ns/10ps
interface etw_if;
    logic scl;
    logic sda;
    logic mst_sda_o;
    logic mst_sda_oe;
    logic dev_sda_o;
    logic dev_sda_oe;
    logic aux_clock_write_enable_pin;
    // wired-and of both drivers with a pull-up
    assign sda = ~((mst_sda_oe & ~mst_sda_o) | (dev_sda_oe & ~dev_sda_o));
    modport dev (input scl, input sda, input aux_clock_write_enable_pin,
                 output dev_sda_o, output dev_sda_oe);
    modport mst (output scl, output mst_sda_o, output mst_sda_oe,
                 output aux_clock_write_enable_pin, input sda);
endinterface : etw_if

/* verilog/etw_eeprom_dev.sv */
// etw_eeprom_dev: EEPROM slave end, link logic on i_lclk, write timer on i_mclk.
// assumes i_lclk runs free and is several times faster than the serial clock.
`timescale 1ns/10ps
module etw_eeprom_dev #(
    parameter int T_WR_CYC = etw_pkg::T_WR_CYC
) (
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic i_ce,
    input wire logic i_lclk,
    etw_if.dev bus,
    output logic o_prog_busy,
    output logic o_prog_done
);
    localparam int SY_RST = 0;
    localparam int SY_CE = 1;
    localparam int SY_SCL = 2;
    localparam int SY_SDA = 3;
    localparam int SY_WEN = 4;
    localparam int SY_DONE = 5;

    logic [5:0] sy1_r;
    logic [5:0] sy2_r;
    logic scl_prv_r;
    logic sda_prv_r;
    logic done_prv_r;
    logic [7:0] mem [etw_pkg::MEM_DEPTH];
    etw_pkg::etw_dst_t st_r, st_nxt, after_r, after_nxt;
    logic [3:0] cnt_r, cnt_nxt;
    logic [7:0] sr_r, sr_nxt, tx_r, tx_nxt;
    logic oe_r, oe_nxt, pend_r, pend_nxt, busy_r, busy_nxt, req_r, req_nxt;
    logic ackm_r, ackm_nxt;
    logic [etw_pkg::ADDR_W-1:0] addr_r, addr_nxt;
    logic [etw_pkg::PAGE_BYTES-1:0] pmask_r, pmask_nxt;
    logic [7:0] pbuf_r [etw_pkg::PAGE_BYTES];
    logic [7:0] pbuf_nxt [etw_pkg::PAGE_BYTES];
    logic lrst, lce, scl, sda, wen, rise, fall, start, stop, done_evt;
    logic [7:0] rd_byte;
    // user-clock timer state, declared early since the link synchroniser samples its toggle
    logic [2:0] ms_r;
    logic run_r, run_nxt, done_tgl_r, done_tgl_nxt, pdone_r, pdone_nxt;
    logic [16:0] wcnt_r, wcnt_nxt;

    // two-flop synchronisers for everything entering the link domain
    always_ff @(posedge i_lclk) begin
        sy1_r <= {done_tgl_r, bus.aux_clock_write_enable_pin, bus.sda, bus.scl, i_ce, i_rst};
        sy2_r <= sy1_r;
    end

    assign lrst = sy2_r[SY_RST];
    assign lce = sy2_r[SY_CE];
    assign scl = sy2_r[SY_SCL];
    assign sda = sy2_r[SY_SDA];
    assign wen = sy2_r[SY_WEN];
    // conditions seen on the synchronised lines
    assign rise = scl & ~scl_prv_r;
    assign fall = ~scl & scl_prv_r;
    assign start = scl & scl_prv_r & sda_prv_r & ~sda;
    assign stop = scl & scl_prv_r & ~sda_prv_r & sda;
    assign done_evt = sy2_r[SY_DONE] ^ done_prv_r;
    assign rd_byte = mem[addr_r];

    // link state machine
    always_comb begin
        st_nxt = st_r;
        after_nxt = after_r;
        cnt_nxt = cnt_r;
        sr_nxt = sr_r;
        tx_nxt = tx_r;
        oe_nxt = oe_r;
        addr_nxt = addr_r;
        pmask_nxt = pmask_r;
        pbuf_nxt = pbuf_r;
        pend_nxt = pend_r;
        busy_nxt = busy_r;
        req_nxt = req_r;
        ackm_nxt = ackm_r;
        if (done_evt) begin
            busy_nxt = 1'b0;
        end
        if (start) begin
            st_nxt = etw_pkg::D_ADDR;
            cnt_nxt = 4'h0;
            oe_nxt = 1'b0;
        end else if (stop) begin
            st_nxt = etw_pkg::D_IDLE;
            oe_nxt = 1'b0;
            pend_nxt = 1'b0;
            // whole page goes in one cycle; nothing if write-enable pin is low
            if (pend_r && wen && !busy_r) begin
                busy_nxt = 1'b1;
                req_nxt = ~req_r;
            end
        end else begin
            case (st_r)
                etw_pkg::D_ADDR, etw_pkg::D_WADR, etw_pkg::D_WDAT: begin
                    if (rise) begin
                        sr_nxt = {sr_r[6:0], sda};
                        cnt_nxt = cnt_r + 4'h1;
                    end else if (fall && cnt_r == etw_pkg::BYTE_BITS) begin
                        cnt_nxt = 4'h0;
                        st_nxt = etw_pkg::D_ACK;
                        oe_nxt = 1'b1;
                        after_nxt = etw_pkg::D_WDAT;
                        if (st_r == etw_pkg::D_ADDR) begin
                            // busy or foreign address: stay off the bus
                            if (sr_r[7:4] != etw_pkg::DEV_TYPE || busy_r) begin
                                st_nxt = etw_pkg::D_WAIT;
                                oe_nxt = 1'b0;
                            end
                            after_nxt = sr_r[0] ? etw_pkg::D_RDAT : etw_pkg::D_WADR;
                        end else if (st_r == etw_pkg::D_WADR) begin
                            addr_nxt = sr_r[etw_pkg::ADDR_W-1:0];
                            pmask_nxt = '0;
                        end else if (wen) begin
                            pbuf_nxt[addr_r[etw_pkg::PAGE_W-1:0]] = sr_r;
                            pmask_nxt[addr_r[etw_pkg::PAGE_W-1:0]] = 1'b1;
                            pend_nxt = 1'b1;
                            addr_nxt[etw_pkg::PAGE_W-1:0] =
                                addr_r[etw_pkg::PAGE_W-1:0] + 4'h1;
                        end else begin
                            addr_nxt[etw_pkg::PAGE_W-1:0] =
                                addr_r[etw_pkg::PAGE_W-1:0] + 4'h1;
                        end
                    end
                end
                etw_pkg::D_ACK: begin
                    if (fall) begin
                        st_nxt = after_r;
                        oe_nxt = 1'b0;
                        if (after_r == etw_pkg::D_RDAT) begin
                            tx_nxt = rd_byte;
                            oe_nxt = ~rd_byte[7];
                        end
                    end
                end
                etw_pkg::D_RDAT: begin
                    if (rise) begin
                        cnt_nxt = cnt_r + 4'h1;
                    end else if (fall) begin
                        if (cnt_r == etw_pkg::BYTE_BITS) begin
                            // release for the master's ack bit
                            cnt_nxt = 4'h0;
                            oe_nxt = 1'b0;
                            st_nxt = etw_pkg::D_RACK;
                            addr_nxt = addr_r + 7'h01;
                        end else begin
                            tx_nxt = {tx_r[6:0], 1'b0};
                            oe_nxt = ~tx_r[6];
                        end
                    end
                end
                etw_pkg::D_RACK: begin
                    if (rise) begin
                        ackm_nxt = ~sda;
                    end else if (fall) begin
                        if (ackm_r) begin
                            st_nxt = etw_pkg::D_RDAT;
                            tx_nxt = rd_byte;
                            oe_nxt = ~rd_byte[7];
                        end else begin
                            st_nxt = etw_pkg::D_WAIT;
                        end
                    end
                end
                default: begin
                    oe_nxt = 1'b0;
                end
            endcase
        end
    end

    // link registers; page buffer is data and keeps no reset
    always_ff @(posedge i_lclk) begin
        if (lrst) begin
            st_r <= etw_pkg::D_IDLE;
            after_r <= etw_pkg::D_IDLE;
            cnt_r <= 4'h0;
            sr_r <= 8'h00;
            tx_r <= 8'h00;
            oe_r <= 1'b0;
            addr_r <= 7'h00;
            pmask_r <= 16'h0000;
            pend_r <= 1'b0;
            busy_r <= 1'b0;
            req_r <= 1'b0;
            ackm_r <= 1'b0;
            scl_prv_r <= 1'b1;
            sda_prv_r <= 1'b1;
            done_prv_r <= 1'b0;
        end else if (lce) begin
            st_r <= st_nxt;
            after_r <= after_nxt;
            cnt_r <= cnt_nxt;
            sr_r <= sr_nxt;
            tx_r <= tx_nxt;
            oe_r <= oe_nxt;
            addr_r <= addr_nxt;
            pmask_r <= pmask_nxt;
            pend_r <= pend_nxt;
            busy_r <= busy_nxt;
            req_r <= req_nxt;
            ackm_r <= ackm_nxt;
            scl_prv_r <= scl;
            sda_prv_r <= sda;
            done_prv_r <= sy2_r[SY_DONE];
            pbuf_r <= pbuf_nxt;
        end
    end

    // commit the page when the timer reports the end of the cycle
    always_ff @(posedge i_lclk) begin
        if (!lrst && lce && done_evt) begin
            for (int i = 0; i < etw_pkg::PAGE_BYTES; i++) begin
                if (pmask_r[i]) begin
                    mem[{addr_r[etw_pkg::ADDR_W-1:etw_pkg::PAGE_W], 4'(i)}] <= pbuf_r[i];
                end
            end
        end
    end

    assign bus.dev_sda_o = 1'b0;
    assign bus.dev_sda_oe = oe_r;

    // user-clock side: programming timer behind a toggle handshake
    always_comb begin
        run_nxt = run_r;
        wcnt_nxt = wcnt_r;
        done_tgl_nxt = done_tgl_r;
        pdone_nxt = 1'b0;
        if (ms_r[2] ^ ms_r[1]) begin
            run_nxt = 1'b1;
            wcnt_nxt = 17'h00000;
        end else if (run_r) begin
            if (wcnt_r == 17'(T_WR_CYC - 1)) begin
                run_nxt = 1'b0;
                done_tgl_nxt = ~done_tgl_r;
                pdone_nxt = 1'b1;
            end else begin
                wcnt_nxt = wcnt_r + 17'h00001;
            end
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            ms_r <= 3'h0;
            run_r <= 1'b0;
            wcnt_r <= 17'h00000;
            done_tgl_r <= 1'b0;
            pdone_r <= 1'b0;
        end else if (i_ce) begin
            ms_r <= {ms_r[1:0], req_r};
            run_r <= run_nxt;
            wcnt_r <= wcnt_nxt;
            done_tgl_r <= done_tgl_nxt;
            pdone_r <= pdone_nxt;
        end
    end

    assign o_prog_busy = run_r;
    assign o_prog_done = pdone_r;
endmodule : etw_eeprom_dev

/* verilog/etw_bus_master.sv */
// etw_bus_master: host end, makes the serial clock from i_mclk and runs one command at a time.
// assumes a single master on the link and no clock stretching by the device.
`timescale 1ns/10ps
module etw_bus_master (
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic i_ce,
    input wire logic i_cmd_valid,
    input wire logic [1:0] i_cmd,
    input wire logic [7:0] i_wdata,
    input wire logic i_rd_ack,
    input wire logic i_wr_enable,
    output logic o_ready,
    output logic o_done,
    output logic [7:0] o_rdata,
    output logic o_ack,
    etw_if.mst bus
);
    logic s1_r, s2_r;
    etw_pkg::etw_mst_t st_r, st_nxt;
    logic [5:0] qc_r, qc_nxt;
    logic [1:0] ph_r, ph_nxt;
    logic [3:0] bit_r, bit_nxt;
    logic [7:0] sh_r, sh_nxt, rdata_r, rdata_nxt;
    logic rd_r, rd_nxt, rdack_r, rdack_nxt, scl_r, scl_nxt, oe_r, oe_nxt;
    logic ready_r, ready_nxt, done_r, done_nxt, ack_r, ack_nxt, wen_r;
    logic tick, fin;

    assign tick = (qc_r == etw_pkg::QTR_LAST);

    // quarter-period sequencer for start, stop and nine-bit bytes
    always_comb begin
        st_nxt = st_r;
        qc_nxt = 6'h00;
        ph_nxt = ph_r;
        bit_nxt = bit_r;
        sh_nxt = sh_r;
        rd_nxt = rd_r;
        rdack_nxt = rdack_r;
        scl_nxt = scl_r;
        oe_nxt = oe_r;
        ready_nxt = ready_r;
        rdata_nxt = rdata_r;
        ack_nxt = ack_r;
        done_nxt = 1'b0;
        fin = 1'b0;
        if (st_r == etw_pkg::M_IDLE) begin
            ph_nxt = 2'h0;
            bit_nxt = 4'h0;
            if (i_cmd_valid && ready_r) begin
                ready_nxt = 1'b0;
                sh_nxt = i_wdata;
                rd_nxt = (i_cmd == etw_pkg::CMD_READ);
                rdack_nxt = i_rd_ack;
                case (i_cmd)
                    etw_pkg::CMD_START: st_nxt = etw_pkg::M_START;
                    etw_pkg::CMD_STOP: st_nxt = etw_pkg::M_STOP;
                    default: st_nxt = etw_pkg::M_BYTE;
                endcase
            end else if (!i_cmd_valid) begin
                // idle with no request standing: offer to take the next one
                ready_nxt = 1'b1;
            end
        end else begin
            qc_nxt = tick ? 6'h00 : qc_r + 6'h01;
            if (tick) begin
                ph_nxt = ph_r + 2'h1;
                case (st_r)
                    etw_pkg::M_START: begin
                        // data falls while clock is high, then clock drops
                        case (ph_r)
                            2'h0: begin
                                scl_nxt = 1'b0;
                                oe_nxt = 1'b0;
                            end
                            2'h1: scl_nxt = 1'b1;
                            2'h2: oe_nxt = 1'b1;
                            default: begin
                                scl_nxt = 1'b0;
                                fin = 1'b1;
                            end
                        endcase
                    end
                    etw_pkg::M_STOP: begin
                        case (ph_r)
                            2'h0: begin
                                scl_nxt = 1'b0;
                                oe_nxt = 1'b1;
                            end
                            2'h1: scl_nxt = 1'b1;
                            2'h2: oe_nxt = 1'b0;
                            default: fin = 1'b1;
                        endcase
                    end
                    default: begin
                        case (ph_r)
                            2'h0: begin
                                if (bit_r == etw_pkg::BYTE_BITS) begin
                                    oe_nxt = rd_r & rdack_r;
                                end else begin
                                    oe_nxt = ~rd_r & ~sh_r[7];
                                end
                            end
                            2'h1: scl_nxt = 1'b1;
                            2'h2: begin
                                if (bit_r == etw_pkg::BYTE_BITS) begin
                                    ack_nxt = rd_r ? rdack_r : ~s2_r;
                                end else begin
                                    sh_nxt = {sh_r[6:0], s2_r};
                                end
                            end
                            default: begin
                                scl_nxt = 1'b0;
                                if (bit_r == etw_pkg::BYTE_BITS) begin
                                    rdata_nxt = sh_r;
                                    fin = 1'b1;
                                end else begin
                                    bit_nxt = bit_r + 4'h1;
                                end
                            end
                        endcase
                    end
                endcase
            end
            if (fin) begin
                st_nxt = etw_pkg::M_IDLE;
                ready_nxt = 1'b1;
                done_nxt = 1'b1;
            end
        end
    end

    // data line comes from the other domain; two flops before use
    always_ff @(posedge i_mclk) begin
        s1_r <= bus.sda;
        s2_r <= s1_r;
    end

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            st_r <= etw_pkg::M_IDLE;
            qc_r <= 6'h00;
            ph_r <= 2'h0;
            bit_r <= 4'h0;
            sh_r <= 8'h00;
            rd_r <= 1'b0;
            rdack_r <= 1'b0;
            scl_r <= 1'b1;
            oe_r <= 1'b0;
            ready_r <= 1'b0;
            done_r <= 1'b0;
            rdata_r <= 8'h00;
            ack_r <= 1'b0;
            wen_r <= 1'b0;
        end else if (i_ce) begin
            st_r <= st_nxt;
            qc_r <= qc_nxt;
            ph_r <= ph_nxt;
            bit_r <= bit_nxt;
            sh_r <= sh_nxt;
            rd_r <= rd_nxt;
            rdack_r <= rdack_nxt;
            scl_r <= scl_nxt;
            oe_r <= oe_nxt;
            ready_r <= ready_nxt;
            done_r <= done_nxt;
            rdata_r <= rdata_nxt;
            ack_r <= ack_nxt;
            wen_r <= i_wr_enable;
        end
    end

    assign bus.scl = scl_r;
    assign bus.mst_sda_o = 1'b0;
    assign bus.mst_sda_oe = oe_r;
    assign bus.aux_clock_write_enable_pin = wen_r;
    assign o_ready = ready_r;
    assign o_done = done_r;
    assign o_rdata = rdata_r;
    assign o_ack = ack_r;
endmodule : etw_bus_master

/* testbench/etw_monitor.sv */
// etw_monitor: wire-level checks on the two-wire link between both ends.
// assumes scl is made from i_mclk, so one clock domain serves every check.
`timescale 1ns/10ps
module etw_monitor (
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic scl,
    input wire logic sda,
    input wire logic mst_sda_oe,
    input wire logic dev_sda_o,
    input wire logic dev_sda_oe
);
    default clocking @(posedge i_mclk); endclocking
    default disable iff (i_rst);
    logic scl_r, sda_r, rd_r, rd_nxt, hit_r, hit_nxt, nak_r, nak_nxt;
    logic [3:0] bit_r, bit_nxt;
    logic [4:0] byt_r, byt_nxt;
    logic [7:0] sh_r, sh_nxt;
    logic rise, cond, ninth;
    assign rise = scl & ~scl_r;
    assign cond = scl & scl_r & (sda != sda_r);
    assign ninth = rise & (bit_r == 4'h8);
    // frame tracker; start and stop both reset it, byte count saturates
    always_comb begin
        bit_nxt = bit_r;
        byt_nxt = byt_r;
        sh_nxt = sh_r;
        rd_nxt = rd_r;
        hit_nxt = hit_r;
        nak_nxt = nak_r;
        if (cond) begin
            bit_nxt = 4'h0;
            byt_nxt = 5'h00;
            hit_nxt = 1'b0;
            rd_nxt = 1'b0;
            nak_nxt = 1'b0;
        end else if (ninth) begin
            bit_nxt = 4'h0;
            byt_nxt = (byt_r == 5'h1F) ? byt_r : byt_r + 5'h01;
            if (byt_r == 5'h00) begin
                hit_nxt = dev_sda_oe;
                rd_nxt = sh_r[0];
            end else if (rd_r && sda) begin
                nak_nxt = 1'b1;
            end
        end else if (rise) begin
            bit_nxt = bit_r + 4'h1;
            sh_nxt = {sh_r[6:0], sda};
        end
    end
    // registers only; line idle levels after reset
    always_ff @(posedge i_mclk) begin
        scl_r <= i_rst ? 1'b1 : scl;
        sda_r <= i_rst ? 1'b1 : sda;
        bit_r <= i_rst ? 4'h0 : bit_nxt;
        byt_r <= i_rst ? 5'h00 : byt_nxt;
        sh_r <= i_rst ? 8'h00 : sh_nxt;
        rd_r <= i_rst ? 1'b0 : rd_nxt;
        hit_r <= i_rst ? 1'b0 : hit_nxt;
        nak_r <= i_rst ? 1'b0 : nak_nxt;
    end
    a_oe_scl_low: assert property ($changed(dev_sda_oe) |-> !scl)
        else $error("device enable moved with scl high");
    a_open_drain: assert property (dev_sda_oe |-> dev_sda_o == 1'b0)
        else $error("device drives data high");
    a_one_driver: assert property (scl |-> !(mst_sda_oe && dev_sda_oe))
        else $error("both ends pull data with scl high");
    a_ack_held: assert property (ninth && dev_sda_oe |-> dev_sda_oe [*8])
        else $error("ack dropped during ninth clock");
    a_addr_match: assert property (ninth && byt_r == 5'h00 && dev_sda_oe |->
        sh_r[7:4] == etw_pkg::DEV_TYPE)
        else $error("ack on foreign address");
    a_write_ack: assert property (ninth && byt_r != 5'h00 && hit_r && !rd_r |-> dev_sda_oe)
        else $error("written byte not acked");
    a_read_release: assert property (ninth && byt_r != 5'h00 && rd_r |-> !dev_sda_oe)
        else $error("device holds data in read ack slot");
    a_nack_idle: assert property (nak_r |-> !dev_sda_oe)
        else $error("device drives after master nack");
    c_addr_ack: cover property (ninth && byt_r == 5'h00 && dev_sda_oe);
    c_read_nack: cover property ($rose(nak_r));
    c_page_wrap: cover property (ninth && byt_r == 5'h11 && !rd_r);
endmodule : etw_monitor

/* testbench/etw_eeprom_two_wire_slave_tb.sv */
// etw_eeprom_two_wire_slave_tb: runs master commands against the device end and checks them.
// assumes a shared reset; the programming timer is shortened for simulation.
`timescale 1ns/10ps
module etw_eeprom_two_wire_slave_tb;
    localparam int T_WR = 2000;
    logic i_mclk, i_lclk, i_rst, i_cmd_valid, i_rd_ack, i_wr_enable;
    logic [1:0] i_cmd;
    logic [7:0] i_wdata, o_rdata;
    logic o_ready, o_done, o_ack, o_prog_busy, o_prog_done;
    logic [7:0] exp_mem [128];
    int num_errors = 0;
    int total_checks = 0;
    etw_if link ();
    etw_eeprom_dev #(.T_WR_CYC(T_WR)) u_etw_eeprom_dev (.i_mclk(i_mclk), .i_rst(i_rst),
        .i_ce(1'b1), .i_lclk(i_lclk), .bus(link), .o_prog_busy(o_prog_busy),
        .o_prog_done(o_prog_done));
    etw_bus_master u_etw_bus_master (.i_mclk(i_mclk), .i_rst(i_rst), .i_ce(1'b1),
        .i_cmd_valid(i_cmd_valid), .i_cmd(i_cmd), .i_wdata(i_wdata), .i_rd_ack(i_rd_ack),
        .i_wr_enable(i_wr_enable), .o_ready(o_ready), .o_done(o_done), .o_rdata(o_rdata),
        .o_ack(o_ack), .bus(link));
    etw_monitor u_etw_monitor (.i_mclk(i_mclk), .i_rst(i_rst), .scl(link.scl), .sda(link.sda),
        .mst_sda_oe(link.mst_sda_oe), .dev_sda_o(link.dev_sda_o), .dev_sda_oe(link.dev_sda_oe));
    // user clock and an unrelated link clock
    initial begin
        i_mclk = 1'b0;
        forever #20 i_mclk = ~i_mclk;
    end
    initial begin
        i_lclk = 1'b0;
        #7;
        forever #15 i_lclk = ~i_lclk;
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    // one command: wait for ready, request for one edge, wait for done
    task automatic cmd(input etw_pkg::etw_cmd_t c, input logic [7:0] d, input logic ack);
        int n = 0;
        while (o_ready !== 1'b1 && n < 3000) begin
            @(posedge i_mclk);
            n++;
        end
        i_cmd_valid <= 1'b1;
        i_cmd <= c;
        i_wdata <= d;
        i_rd_ack <= ack;
        @(posedge i_mclk);
        i_cmd_valid <= 1'b0;
        n = 0;
        do begin
            @(posedge i_mclk);
            n++;
        end while (o_done !== 1'b1 && n < 3000);
        if (n >= 3000) chk(8'h00, 8'h01);
    endtask : cmd
    task automatic wr(input logic [7:0] d, input logic ack);
        cmd(etw_pkg::CMD_WRITE, d, 1'b0);
        chk({7'h00, o_ack}, {7'h00, ack});
    endtask : wr
    task automatic rd(input logic ack, input logic [7:0] d);
        cmd(etw_pkg::CMD_READ, 8'h00, ack);
        chk(o_rdata, d);
    endtask : rd
    // dummy write of the byte address, then repeated start for reading
    task automatic sel_read(input logic [7:0] a);
        cmd(etw_pkg::CMD_START, 8'h00, 1'b0);
        wr(8'hA0, 1'b1);
        wr(a, 1'b1);
        cmd(etw_pkg::CMD_START, 8'h00, 1'b0);
        wr(8'hA1, 1'b1);
    endtask : sel_read
    task automatic wait_prog();
        int n = 0;
        while (o_prog_done !== 1'b1 && n < 3000) begin
            @(posedge i_mclk);
            n++;
        end
        chk({7'h00, o_prog_done}, 8'h01);
    endtask : wait_prog
    task automatic print_verdict();
        if (num_errors == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : print_verdict
    // hang guard well beyond the expected 30k cycles
    initial begin
        repeat (60000) @(posedge i_mclk);
        num_errors++;
        print_verdict();
    end
    initial begin
        i_rst = 1'b1;
        i_cmd_valid = 1'b0;
        i_cmd = 2'h0;
        i_wdata = 8'h00;
        i_rd_ack = 1'b0;
        i_wr_enable = 1'b1;
        repeat (20) @(posedge i_mclk);
        i_rst <= 1'b0;
        // byte write to the top cell, then poll at once while busy
        cmd(etw_pkg::CMD_START, 8'h00, 1'b0);
        wr(8'hA0, 1'b1);
        wr(8'h7F, 1'b1);
        wr(8'hC3, 1'b1);
        cmd(etw_pkg::CMD_STOP, 8'h00, 1'b0);
        exp_mem[127] = 8'hC3;
        chk({7'h00, o_prog_busy}, 8'h01);
        // pin may drop once the cycle runs; the later read proves the byte landed
        i_wr_enable <= 1'b0;
        cmd(etw_pkg::CMD_START, 8'h00, 1'b0);
        wr(8'hA0, 1'b0);
        cmd(etw_pkg::CMD_STOP, 8'h00, 1'b0);
        wait_prog();
        i_wr_enable <= 1'b1;
        cmd(etw_pkg::CMD_START, 8'h00, 1'b0);
        wr(8'hAE, 1'b1);
        cmd(etw_pkg::CMD_START, 8'h00, 1'b0);
        wr(8'h90, 1'b0);
        cmd(etw_pkg::CMD_STOP, 8'h00, 1'b0);
        // eighteen bytes from offset 14 wrap inside page 0
        cmd(etw_pkg::CMD_START, 8'h00, 1'b0);
        wr(8'hA0, 1'b1);
        wr(8'h0E, 1'b1);
        for (int i = 0; i < 18; i++) begin
            wr(8'(8'h10 + i), 1'b1);
            exp_mem[(14 + i) % 16] = 8'(8'h10 + i);
        end
        cmd(etw_pkg::CMD_STOP, 8'h00, 1'b0);
        wait_prog();
        // read the top cell and run on past the wrap
        sel_read(8'h7F);
        rd(1'b1, exp_mem[127]);
        for (int k = 0; k < 3; k++) rd(k < 2, exp_mem[k]);
        cmd(etw_pkg::CMD_STOP, 8'h00, 1'b0);
        cmd(etw_pkg::CMD_START, 8'h00, 1'b0);
        wr(8'hA1, 1'b1);
        rd(1'b0, exp_mem[3]);
        rd(1'b0, 8'hFF);
        cmd(etw_pkg::CMD_STOP, 8'h00, 1'b0);
        // pin low: bytes still acked, nothing programmed
        i_wr_enable <= 1'b0;
        cmd(etw_pkg::CMD_START, 8'h00, 1'b0);
        wr(8'hA0, 1'b1);
        wr(8'h00, 1'b1);
        wr(8'h99, 1'b1);
        cmd(etw_pkg::CMD_STOP, 8'h00, 1'b0);
        repeat (50) @(posedge i_mclk);
        chk({7'h00, o_prog_busy}, 8'h00);
        i_wr_enable <= 1'b1;
        sel_read(8'h00);
        rd(1'b0, exp_mem[0]);
        cmd(etw_pkg::CMD_STOP, 8'h00, 1'b0);
        print_verdict();
    end
endmodule : etw_eeprom_two_wire_slave_tb
